// ==== test/tdf_link_props.sv ====
// Checker for the two-wire link between the host and target ends
`timescale 1ns/1ps
`default_nettype none
module tdf_link_props (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_halted,
   input wire logic o_prog_enabled,
   input wire logic debug_port_clock,
   input wire logic host_data_out,
   input wire logic host_data_oe,
   input wire logic dev_data_out,
   input wire logic dev_data_oe,
   input wire logic debug_port_data
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   property p_low_phase;
      $fell(debug_port_clock) |-> !debug_port_clock [*8] ##1 debug_port_clock;
   endproperty
   a_low_phase: assert property (p_low_phase) else $error("link clock low phase length wrong");

   property p_high_phase;
      $rose(debug_port_clock) |-> debug_port_clock [*8];
   endproperty
   a_high_phase: assert property (p_high_phase) else $error("link clock high phase too short");

   property p_one_driver;
      !(host_data_oe && dev_data_oe);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive the data line");

   property p_halt_gate;
      !i_halted [*3] |-> !dev_data_oe;
   endproperty
   a_halt_gate: assert property (p_halt_gate) else $error("target drives data while running");

   property p_sticky;
      o_prog_enabled |=> o_prog_enabled;
   endproperty
   a_sticky: assert property (p_sticky) else $error("programming enable dropped without reset");

   property p_start_bit;
      $rose(host_data_oe) |-> !host_data_out && !debug_port_clock;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("frame does not open with low start bit");

   property p_host_hold;
      debug_port_clock && $past(debug_port_clock) && host_data_oe && $past(host_data_oe) |-> $stable(host_data_out);
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("host data moved during high phase");

   property p_dev_launch;
      $rose(dev_data_oe) |-> !debug_port_clock;
   endproperty
   a_dev_launch: assert property (p_dev_launch) else $error("target began driving in high phase");

   property p_wire;
      dev_data_oe |-> debug_port_data == dev_data_out;
   endproperty
   a_wire: assert property (p_wire) else $error("data line does not show target value");

   c_frame: cover property ($fell(debug_port_clock));
   c_dev_drive: cover property ($rose(dev_data_oe));
   c_unlock: cover property ($rose(o_prog_enabled));
endmodule
`default_nettype wire

// ==== test/two_wire_debug_flash_regs_test.sv ====
// Testbench joining host and target ends over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module two_wire_debug_flash_regs_test;
   import tdf_pkg::*;
   localparam tdf_byte_t ID = 8'h3c; // Arbitrary value
   localparam tdf_byte_t REV = 8'h07; // Arbitrary value
   localparam tdf_byte_t FRD = 8'ha7;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_halted = 1'b1;
   tdf_byte_t i_flash_rdata = FRD; // Held steady all run
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, er, o_prog_enabled, o_flash_op_valid, o_flash_byte_valid, o_flash_rd_strobe;
   tdf_byte_t o_flash_op, o_flash_byte, last_op, last_byte;
   int err_total = 0;
   int num_checks = 0;
   int n_op = 0;
   int n_byte = 0;
   int n_rd = 0;

   tdf_link_if link ();
   tdf_host u_tdf_host (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .link(link.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   tdf_target #(.P_PART_ID(ID), .P_REVISION(REV)) u_tdf_target (.i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n), .link(link.dev), .i_halted(i_halted), .i_flash_rdata(i_flash_rdata),
      .o_prog_enabled(o_prog_enabled), .o_flash_op_valid(o_flash_op_valid), .o_flash_op(o_flash_op),
      .o_flash_byte_valid(o_flash_byte_valid), .o_flash_byte(o_flash_byte),
      .o_flash_rd_strobe(o_flash_rd_strobe));
   tdf_link_props u_tdf_link_props (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_halted(i_halted),
      .o_prog_enabled(o_prog_enabled), .debug_port_clock(link.debug_port_clock),
      .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
      .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
      .debug_port_data(link.debug_port_data));

   always #5 i_ref_clk = ~i_ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Target user side pulse counters
   always @(posedge i_ref_clk) begin
      if (o_flash_op_valid === 1'b1) begin
         n_op <= n_op + 1;
         last_op <= o_flash_op;
      end
      if (o_flash_byte_valid === 1'b1) begin
         n_byte <= n_byte + 1;
         last_byte <= o_flash_byte;
      end
      if (o_flash_rd_strobe === 1'b1) begin
         n_rd <= n_rd + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      @(posedge i_ref_clk);
      while (pready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_ref_clk);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      rd = 32'h1;
      while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 100) begin
         n++;
         apb(1'b0, HOST_STATUS_OFS, 32'h0);
      end
      check(32'({rd[STAT_DONE_BIT], rd[STAT_BUSY_BIT]}), 32'h2);
   endtask

   task automatic frame(input tdf_ins_e ins, input tdf_byte_t b, output tdf_byte_t r);
      apb(1'b1, HOST_CMD_OFS, {16'h0000, b, 6'h00, ins});
      wait_idle();
      r = rd[STAT_RDATA_LSB +: 8];
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_ids;
      tdf_byte_t r;
      frame(INS_ADDR_WRITE, SEL_PART_ID, r);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(ID));
      frame(INS_DATA_WRITE, 8'hff, r);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(ID));
      frame(INS_ADDR_WRITE, SEL_REVISION, r);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(REV));
      frame(INS_ADDR_WRITE, 8'h55, r);
      frame(INS_ADDR_READ, 8'h00, r);
      check(32'(r), 32'h55);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'h0);
      $display("Test ids done");
   endtask

   task automatic t_apb;
      apb(1'b0, 32'h0000_0008, 32'h0);
      check(32'(er), 32'h1);
      apb(1'b1, HOST_STATUS_OFS, 32'h0);
      check(32'(er), 32'h1);
      apb(1'b1, HOST_CMD_OFS, 32'(INS_ADDR_READ));
      check(32'(er), 32'h0);
      apb(1'b1, HOST_CMD_OFS, 32'h0);
      check(32'(er), 32'h1);
      wait_idle();
      check(32'(er), 32'h0);
      check(32'(rd[STAT_RDATA_LSB +: 8]), 32'h55);
      $display("Test apb done");
   endtask

   task automatic t_locked;
      tdf_byte_t r;
      tdf_byte_t seq[6] = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h01};
      frame(INS_ADDR_WRITE, SEL_DATA_PORT, r);
      frame(INS_DATA_WRITE, CMD_BLOCK_WRITE, r);
      check(32'(n_op), 32'h0);
      frame(INS_ADDR_WRITE, SEL_UNLOCK_CTL, r);
      for (int i = 0; i < 6; i++) begin
         check(32'(o_prog_enabled), 32'h0);
         frame(INS_DATA_WRITE, seq[i], r);
      end
      check(32'(o_prog_enabled), 32'h1);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(UNLOCK_SECOND));
      $display("Test unlock done");
   endtask

   task automatic t_cmds;
      tdf_byte_t r;
      tdf_byte_t codes[4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
      for (int i = 0; i < 4; i++) begin
         frame(INS_ADDR_WRITE, SEL_DATA_PORT, r);
         frame(INS_DATA_WRITE, 8'h09, r);
         check(32'(n_op), 32'(i));
         frame(INS_DATA_WRITE, codes[i], r);
         check(32'(n_op), 32'(i + 1));
         check(32'(last_op), 32'(codes[i]));
         frame(INS_DATA_WRITE, 8'(8'h40 + i), r);
         check(32'(n_byte), 32'(i + 1));
         check(32'(last_byte), 32'(8'h40 + i));
      end
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(FRD));
      check(32'(n_rd), 32'h1);
      $display("Test commands done");
   endtask

   task automatic t_halt;
      tdf_byte_t r;
      i_halted <= 1'b0;
      @(posedge i_ref_clk);
      frame(INS_ADDR_WRITE, SEL_PART_ID, r);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'hff);
      i_halted <= 1'b1;
      @(posedge i_ref_clk);
      frame(INS_DATA_READ, 8'h00, r);
      check(32'(r), 32'(FRD));
      check(32'(n_rd), 32'h2);
      $display("Test halt done");
   endtask

   task automatic t_reset;
      tdf_byte_t r;
      check(32'(o_prog_enabled), 32'h1);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      check(32'(o_prog_enabled), 32'h0);
      frame(INS_ADDR_WRITE, SEL_DATA_PORT, r);
      frame(INS_DATA_WRITE, CMD_PAGE_ERASE, r);
      check(32'(n_op), 32'h4);
      $display("Test reset done");
   endtask

   task automatic test_done;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_ref_clk);
      err_total++;
      $display("MISMATCH at %0t: timeout", $time);
      test_done();
   end

   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      t_ids();
      t_apb();
      t_locked();
      t_cmds();
      t_halt();
      t_reset();
      test_done();
   end
endmodule
`default_nettype wire

// ==== verilog/tdf_host.sv ====
// Host end: APB command registers driving frames onto the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tdf_host (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   tdf_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import tdf_pkg::*;

   typedef struct packed {
      tdf_hst_state_e state;
      logic [3:0] div;
      logic [3:0] idx;
      tdf_ins_e ins;
      tdf_byte_t wdata;
      tdf_byte_t rshift;
      tdf_byte_t rdata;
      logic busy;
      logic done;
      logic clk_out;
      logic dat_out;
      logic dat_oe;
      logic dat_s1;
      logic dat_s2;
      logic [31:0] prdata;
   } tdf_hst_s;

   tdf_hst_s q;
   tdf_hst_s d;
   logic is_read;
   logic access;
   logic start;

   function automatic logic host_bit(input logic [3:0] idx, input tdf_ins_e ins, input tdf_byte_t w);
      logic b;
      if (idx == 4'd0) begin
         b = 1'b0;
      end else if (idx < FRAME_HDR_BITS) begin
         b = ins[idx[0] ? 0 : 1];
      end else begin
         b = w[3'(idx - FRAME_HDR_BITS)];
      end
      return b;
   endfunction

   always_comb begin
      d = q;
      d.dat_s1 = link.debug_port_data;
      d.dat_s2 = q.dat_s1;
      is_read = (q.ins == INS_DATA_READ) || (q.ins == INS_ADDR_READ);
      access = psel & penable;
      start = access & pwrite & (paddr == HOST_CMD_OFS) & ~q.busy;
      // Read data sampled in the setup cycle, zero-wait access
      if (psel && !penable) begin
         d.prdata = 32'h0000_0000;
         if (paddr == HOST_STATUS_OFS) begin
            d.prdata[STAT_BUSY_BIT] = q.busy;
            d.prdata[STAT_DONE_BIT] = q.done;
            d.prdata[STAT_RDATA_LSB +: 8] = q.rdata;
         end
      end
      case (q.state)
         HST_IDLE: begin
            d.clk_out = 1'b1;
            d.dat_oe = 1'b0;
            if (start) begin
               d.ins = tdf_ins_e'(pwdata[CMD_INS_LSB +: 2]);
               d.wdata = pwdata[CMD_WDATA_LSB +: 8];
               d.busy = 1'b1;
               d.done = 1'b0;
               d.idx = 4'd0;
               d.div = 4'd0;
               d.clk_out = 1'b0;
               d.dat_oe = 1'b1;
               d.dat_out = 1'b0;
               d.state = HST_LOW;
            end
         end
         HST_LOW: begin
            d.div = q.div + 4'd1;
            if (q.div == LINK_HALF_CYC - 4'd1) begin
               if (is_read && q.idx >= FRAME_HDR_BITS) begin
                  d.rshift = {q.dat_s2, q.rshift[7:1]};
               end
               d.div = 4'd0;
               d.clk_out = 1'b1;
               d.state = HST_HIGH;
            end
         end
         HST_HIGH: begin
            d.div = q.div + 4'd1;
            if (q.div == LINK_HALF_CYC - 4'd1) begin
               d.div = 4'd0;
               if (q.idx == FRAME_LAST_BIT) begin
                  d.state = HST_IDLE;
                  d.dat_oe = 1'b0;
                  d.busy = 1'b0;
                  d.done = 1'b1;
                  if (is_read) begin
                     d.rdata = q.rshift;
                  end
               end else begin
                  d.idx = q.idx + 4'd1;
                  d.clk_out = 1'b0;
                  d.state = HST_LOW;
                  d.dat_oe = !(is_read && (q.idx + 4'd1) >= FRAME_HDR_BITS);
                  d.dat_out = host_bit(q.idx + 4'd1, q.ins, q.wdata);
               end
            end
         end
         default: begin
            d.state = HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '{state: HST_IDLE, ins: INS_DATA_READ, clk_out: 1'b1, dat_s1: 1'b1, dat_s2: 1'b1,
                default: '0};
      end else begin
         q <= d;
      end
   end

   assign link.debug_port_clock = q.clk_out;
   assign link.host_data_out = q.dat_out;
   assign link.host_data_oe = q.dat_oe;
   assign prdata = q.prdata;
   assign pready = 1'b1;
   assign pslverr = access & ((paddr != HOST_CMD_OFS && paddr != HOST_STATUS_OFS) ||
                              (paddr == HOST_CMD_OFS && pwrite && q.busy) ||
                              (paddr == HOST_STATUS_OFS && pwrite));
endmodule
`default_nettype wire

// ==== verilog/tdf_link_if.sv ====
// Two-wire link between host adapter and target: clock line and shared data line
`timescale 1ns/1ps
`default_nettype none
interface tdf_link_if;
   logic debug_port_clock;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic debug_port_data;

   // Resolved wire level, pulled high when nobody drives
   assign debug_port_data = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 1'b1);

   modport dev (
      input debug_port_clock,
      input debug_port_data,
      output dev_data_out,
      output dev_data_oe
   );

   modport host (
      output debug_port_clock,
      output host_data_out,
      output host_data_oe,
      input debug_port_data
   );
endinterface
`default_nettype wire

// ==== verilog/tdf_pkg.sv ====
// Shared constants and types for the two-wire debug and flash programming port
`default_nettype none
package tdf_pkg;
   typedef logic [7:0] tdf_byte_t;

   // Target register select values
   localparam tdf_byte_t SEL_PART_ID = 8'h00;
   localparam tdf_byte_t SEL_REVISION = 8'h01;
   localparam tdf_byte_t SEL_UNLOCK_CTL = 8'h02;
   localparam tdf_byte_t SEL_DATA_PORT = 8'hb4;

   // Unlock sequence and flash command codes
   localparam tdf_byte_t UNLOCK_FIRST = 8'h02;
   localparam tdf_byte_t UNLOCK_SECOND = 8'h01;
   localparam tdf_byte_t CMD_BLOCK_READ = 8'h06;
   localparam tdf_byte_t CMD_BLOCK_WRITE = 8'h07;
   localparam tdf_byte_t CMD_PAGE_ERASE = 8'h08;
   localparam tdf_byte_t CMD_DEVICE_ERASE = 8'h03;

   // Link instruction codes, sent low bit first after a zero start bit
   typedef enum logic [1:0] {
      INS_DATA_READ = 2'b00,
      INS_DATA_WRITE = 2'b01,
      INS_ADDR_READ = 2'b10,
      INS_ADDR_WRITE = 2'b11
   } tdf_ins_e;

   // Frame layout: start bit, two instruction bits, eight payload bits
   localparam logic [3:0] FRAME_HDR_BITS = 4'd3;
   localparam logic [3:0] FRAME_LAST_BIT = 4'd10;
   localparam logic [2:0] PAYLOAD_LAST = 3'd7;

   // Link clock timing made by the host
   localparam int REF_CLK_NS = 10;
   localparam int LINK_HALF_NS = 80;
   localparam logic [3:0] LINK_HALF_CYC = 4'((LINK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS);

   // Host APB register map
   localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
   localparam logic [31:0] HOST_STATUS_OFS = 32'h0000_0004;
   localparam int CMD_INS_LSB = 0;
   localparam int CMD_WDATA_LSB = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_RDATA_LSB = 8;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_INSTR = 2'b01,
      DEV_WDATA = 2'b10,
      DEV_RDATA = 2'b11
   } tdf_dev_state_e;

   typedef enum logic [1:0] {
      HST_IDLE = 2'b00,
      HST_LOW = 2'b01,
      HST_HIGH = 2'b10
   } tdf_hst_state_e;
endpackage
`default_nettype wire

// ==== verilog/tdf_target.sv ====
// Target end: debug port registers, unlock logic and flash command decode
//
// Notes on behaviour
// - Select register picks target of data commands
// - Select 0x00 reads the part identity
// - Select 0x01 reads the silicon revision
// - Select 0x02 reaches the unlock control register
// - Select 0xb4 reaches the programming data port
// - Identity is fixed read-only eight bits
// - Writes 0x02 then 0x01 enable programming
// - Programming stays enabled until system reset
// - Data port carries command, address, data bytes
// - Decode 0x06, 0x07, 0x08, 0x03 flash commands
// - Port traffic only while device is halted
// - Shared pins borrowed only while halted
// - Application keeps data input steady while halted
// - Clock/reset pin is input only
// - Host clock plus one two-way data line
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tdf_target #(
   parameter tdf_pkg::tdf_byte_t P_PART_ID = 8'h5a,   // Arbitrary value
   parameter tdf_pkg::tdf_byte_t P_REVISION = 8'h02   // Arbitrary value
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   tdf_link_if.dev link,
   input wire logic i_halted,
   input wire tdf_pkg::tdf_byte_t i_flash_rdata,
   output logic o_prog_enabled,
   output logic o_flash_op_valid,
   output tdf_pkg::tdf_byte_t o_flash_op,
   output logic o_flash_byte_valid,
   output tdf_pkg::tdf_byte_t o_flash_byte,
   output logic o_flash_rd_strobe
);
   import tdf_pkg::*;

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
      logic dat_s1;
      logic dat_s2;
      tdf_dev_state_e state;
      logic [2:0] cnt;
      logic ins0;
      tdf_ins_e ins;
      tdf_byte_t shift;
      tdf_byte_t sel;
      tdf_byte_t ctl;
      logic unlock_stage;
      logic prog_en;
      logic cmd_taken;
      logic drv_oe;
      logic drv_bit;
      logic op_valid;
      tdf_byte_t op;
      logic byte_valid;
      tdf_byte_t byte_out;
      logic rd_strobe;
   } tdf_dev_s;

   tdf_dev_s q;
   tdf_dev_s d;
   logic rise;
   logic fall;
   tdf_ins_e ins_now;
   tdf_byte_t wval;

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode

   function automatic tdf_byte_t reg_read(input tdf_byte_t sel, input tdf_byte_t ctl,
                                          input tdf_byte_t fdata);
      tdf_byte_t v;
      case (sel)
         SEL_PART_ID: v = P_PART_ID;
         SEL_REVISION: v = P_REVISION;
         SEL_UNLOCK_CTL: v = ctl;
         SEL_DATA_PORT: v = fdata;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic is_flash_cmd(input tdf_byte_t v);
      return (v == CMD_BLOCK_READ) || (v == CMD_BLOCK_WRITE) ||
             (v == CMD_PAGE_ERASE) || (v == CMD_DEVICE_ERASE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      d.op_valid = 1'b0;
      d.byte_valid = 1'b0;
      d.rd_strobe = 1'b0;
      // Pins pass two flops before any logic looks at them
      d.clk_s1 = link.debug_port_clock;
      d.clk_s2 = q.clk_s1;
      d.clk_s3 = q.clk_s2;
      d.dat_s1 = link.debug_port_data;
      d.dat_s2 = q.dat_s1;
      rise = q.clk_s2 & ~q.clk_s3;
      fall = ~q.clk_s2 & q.clk_s3;
      ins_now = tdf_ins_e'({q.dat_s2, q.ins0});
      wval = {q.dat_s2, q.shift[7:1]};

      if (!i_halted) begin
         // Running: pins belong to the application
         d.state = DEV_IDLE;
         d.drv_oe = 1'b0;
      end else begin
         case (q.state)
            DEV_IDLE: begin
               if (rise && !q.dat_s2) begin
                  d.state = DEV_INSTR;
                  d.cnt = 3'd0;
               end
            end
            DEV_INSTR: begin
               if (rise) begin
                  if (q.cnt == 3'd0) begin
                     d.ins0 = q.dat_s2;
                     d.cnt = 3'd1;
                  end else begin
                     d.ins = ins_now;
                     d.cnt = 3'd0;
                     if (ins_now == INS_ADDR_READ) begin
                        d.shift = q.sel;
                        d.state = DEV_RDATA;
                     end else if (ins_now == INS_DATA_READ) begin
                        d.shift = reg_read(q.sel, q.ctl, i_flash_rdata);
                        d.rd_strobe = (q.sel == SEL_DATA_PORT);
                        d.state = DEV_RDATA;
                     end else begin
                        d.state = DEV_WDATA;
                     end
                  end
               end
            end
            DEV_WDATA: begin
               if (rise) begin
                  d.shift = wval;
                  d.cnt = q.cnt + 3'd1;
                  if (q.cnt == PAYLOAD_LAST) begin
                     d.state = DEV_IDLE;
                     if (q.ins == INS_ADDR_WRITE) begin
                        d.sel = wval;
                        d.cmd_taken = 1'b0;
                     end else begin
                        case (q.sel)
                           SEL_UNLOCK_CTL: begin
                              d.ctl = wval;
                              if (wval == UNLOCK_FIRST) begin
                                 d.unlock_stage = 1'b1;
                              end else begin
                                 if (q.unlock_stage && wval == UNLOCK_SECOND) begin
                                    d.prog_en = 1'b1;
                                 end
                                 d.unlock_stage = 1'b0;
                              end
                           end
                           SEL_DATA_PORT: begin
                              if (q.prog_en) begin
                                 if (!q.cmd_taken) begin
                                    if (is_flash_cmd(wval)) begin
                                       d.op = wval;
                                       d.op_valid = 1'b1;
                                       d.cmd_taken = 1'b1;
                                    end
                                 end else begin
                                    d.byte_out = wval;
                                    d.byte_valid = 1'b1;
                                 end
                              end
                           end
                           default: begin
                              // Identity, revision and unmapped: writes dropped
                              d.ctl = q.ctl;
                           end
                        endcase
                     end
                  end
               end
            end
            DEV_RDATA: begin
               if (fall) begin
                  d.drv_oe = 1'b1;
                  d.drv_bit = q.shift[0];
                  d.shift = {1'b0, q.shift[7:1]};
               end else if (rise) begin
                  d.cnt = q.cnt + 3'd1;
                  if (q.cnt == PAYLOAD_LAST) begin
                     d.drv_oe = 1'b0;
                     d.state = DEV_IDLE;
                  end
               end
            end
            default: begin
               d.state = DEV_IDLE;
               d.drv_oe = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; only system reset leaves programming mode

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '{clk_s1: 1'b1, clk_s2: 1'b1, clk_s3: 1'b1, dat_s1: 1'b1, dat_s2: 1'b1,
                state: DEV_IDLE, ins: INS_DATA_READ, default: '0};
      end else begin
         q <= d;
      end
   end

   assign link.dev_data_out = q.drv_bit;
   assign link.dev_data_oe = q.drv_oe & i_halted;
   assign o_prog_enabled = q.prog_en;
   assign o_flash_op_valid = q.op_valid;
   assign o_flash_op = q.op;
   assign o_flash_byte_valid = q.byte_valid;
   assign o_flash_byte = q.byte_out;
   assign o_flash_rd_strobe = q.rd_strobe;
endmodule
`default_nettype wire
